/* src/rcr_pkg.sv */
// Purpose: Constants for the reset cause recorder
// Assumes: 8-bit registers on a plain register port
// Notes:   Offsets are local register indices
package rcr_pkg;
	localparam logic [1:0] ADDR_BORCTL = 2'h0;
	localparam logic [1:0] ADDR_PCF    = 2'h1;
	localparam logic [1:0] ADDR_STAT   = 2'h2;
	localparam logic [1:0] ADDR_IRQ    = 2'h3;
	// Interrupt register: status in [3:0], mask in [7:4]
	localparam int BIT_STACK_OVERFLOW_FLAG = 7;
	localparam int BIT_STACK_UNDERFLOW_FLAG = 6;
	localparam int BIT_PINRST = 3;
	localparam int BIT_INSTR  = 2;
	localparam int BIT_POR    = 1;
	localparam int BIT_BOR    = 0;
	localparam int BIT_TO     = 4;
	localparam int BIT_PD     = 3;
	localparam int BIT_SW_BROWNOUT_ENABLE = 7;
	localparam int BIT_BROWNOUT_READY = 0;
	localparam logic [7:0] PCF_IMPL_MASK = 8'hCF;
	localparam logic [7:0] PCF_POR_VAL   = 8'h0C;
	localparam logic [1:0] STAT_POR_VAL  = 2'h3;
	localparam logic [7:0] BORCTL_POR_VAL = 8'h80;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] PC_VECTOR = 16'h0004;
	localparam int IRQ_RST = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_STK = 2;
	localparam int IRQ_BOR = 3;
endpackage : rcr_pkg

/* src/rcr_reset_cause_recorder.sv */
// Purpose: Records the cause of the last reset or wake-up
// Assumes: Event inputs are one-cycle pulses from same-clock logic
// Notes:   Power-on is the async reset; no other reset clears this block
//
// Overview of operation
// - Every reset updates cause flags or status
// - Power-on forces timeout and powerdown to one
// - Power-on pattern: flags 00 1100, status 11
// - Power-on flag cleared by power-on, software sets
// - Brown-out flag cleared by power-on or brown-out
// - Brown-out: fixed flag pattern except power-on flag kept, status 11, PC zero
// - Pin reset clears pin flag; firmware sets it
// - Reset instruction clears its flag only
// - Overflow sets flag; reset only when enabled
// - Underflow sets flag; reset only when enabled
// - Flag bits five and four read zero
// - Watchdog reset clears timeout; wake clears both
// - Interrupt wake: timeout one, powerdown zero
// - Pin reset running: only pin flag cleared
// - Pin reset asleep: timeout one, powerdown zero
// - Interrupt wake with global enable: next, then vector
// - Unimplemented status bits read zero
// - Brown-out control: enable bit7, ready bit0
//
// Local design decisions: the placing of the registers and strobed register access.
module rcr_reset_cause_recorder (
	input  wire logic        ref_clk_in,
	input  wire logic        rstn_in,
	input  wire logic        clk_en_in,
	input  wire logic [1:0]  addr_in,
	input  wire logic [7:0]  wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	input  wire logic        brownout_in,
	input  wire logic        external_reset_pin_in,
	input  wire logic        instr_reset_in,
	input  wire logic        wdt_expire_in,
	input  wire logic        stack_ovf_in,
	input  wire logic        stack_unf_in,
	input  wire logic        irq_wake_in,
	input  wire logic        global_irq_enable_in,
	input  wire logic        sleeping_in,
	input  wire logic        stack_reset_enable_in,
	input  wire logic        brownout_ready_in,
	input  wire logic [15:0] pc_in,
	output logic [7:0]       rdata_out,
	output logic             core_reset_out,
	output logic             pc_load_out,
	output logic [15:0]      pc_value_out,
	output logic             vector_pending_out,
	output logic             sw_brownout_enable_out,
	output logic             irq_out
);
	// ---------------------------------------------
	// Pin synchroniser
	// ---------------------------------------------
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_prev_reg;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_s1_reg   <= 1'b1;
			pin_s2_reg   <= 1'b1;
			pin_prev_reg <= 1'b1;
		end else if (clk_en_in) begin
			pin_s1_reg   <= external_reset_pin_in;
			pin_s2_reg   <= pin_s1_reg;
			pin_prev_reg <= pin_s2_reg;
		end
	end
	// Pin is active low; act on the falling edge only
	wire pin_ev = pin_prev_reg & ~pin_s2_reg;

	// ---------------------------------------------
	// Event decode
	// ---------------------------------------------
	wire bor_ev = brownout_in;
	wire nb     = ~bor_ev;
	wire pin_run = nb & pin_ev & ~sleeping_in;
	wire pin_slp = nb & pin_ev & sleeping_in;
	wire wdt_run = nb & ~pin_ev & wdt_expire_in & ~sleeping_in;
	wire wdt_slp = nb & ~pin_ev & wdt_expire_in & sleeping_in;
	wire irq_wk  = nb & ~pin_ev & ~wdt_expire_in & irq_wake_in & sleeping_in;
	wire ri_ev   = nb & instr_reset_in;
	wire ovf_rst = nb & stack_ovf_in & stack_reset_enable_in;
	wire unf_rst = nb & stack_unf_in & stack_reset_enable_in;
	wire any_rst = bor_ev | pin_run | pin_slp | wdt_run | ri_ev | ovf_rst | unf_rst;
	wire any_wake = wdt_slp | irq_wk;

	wire wr_pcf  = wr_in & (addr_in == rcr_pkg::ADDR_PCF);
	wire wr_bctl = wr_in & (addr_in == rcr_pkg::ADDR_BORCTL);
	wire wr_irq  = wr_in & (addr_in == rcr_pkg::ADDR_IRQ);

	// ---------------------------------------------
	// Power control flags
	// ---------------------------------------------
	logic [7:0] pcf_reg;
	logic [7:0] pcf_next;
	always_comb begin
		pcf_next = pcf_reg;
		if (wr_pcf) begin
			pcf_next = wdata_in;
		end
		if (bor_ev) begin
			pcf_next[rcr_pkg::BIT_STACK_OVERFLOW_FLAG] = 1'b0;
			pcf_next[rcr_pkg::BIT_STACK_UNDERFLOW_FLAG] = 1'b0;
			pcf_next[rcr_pkg::BIT_PINRST] = 1'b1;
			pcf_next[rcr_pkg::BIT_INSTR]  = 1'b1;
			pcf_next[rcr_pkg::BIT_POR]    = pcf_reg[rcr_pkg::BIT_POR];
			pcf_next[rcr_pkg::BIT_BOR]    = 1'b0;
		end
		if (pin_run | pin_slp) begin
			pcf_next[rcr_pkg::BIT_PINRST] = 1'b0;
		end
		if (ri_ev) begin
			pcf_next[rcr_pkg::BIT_INSTR] = 1'b0;
		end
		if (nb & stack_ovf_in) begin
			pcf_next[rcr_pkg::BIT_STACK_OVERFLOW_FLAG] = 1'b1;
		end
		if (nb & stack_unf_in) begin
			pcf_next[rcr_pkg::BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
		end
		pcf_next = pcf_next & rcr_pkg::PCF_IMPL_MASK;
	end

	// ---------------------------------------------
	// Status bits: [1] timeout, [0] powerdown
	// ---------------------------------------------
	logic [1:0] stat_reg;
	logic [1:0] stat_next;
	always_comb begin
		stat_next = stat_reg;
		if (bor_ev) begin
			stat_next = 2'h3;
		end else if (pin_slp | irq_wk) begin
			stat_next = 2'h2;
		end else if (wdt_slp) begin
			stat_next = 2'h0;
		end else if (wdt_run) begin
			stat_next[1] = 1'b0;
		end
	end

	// ---------------------------------------------
	// Brown-out control and interrupts
	// ---------------------------------------------
	logic       sw_brownout_enable_reg;
	logic [3:0] ist_reg;
	logic [3:0] imask_reg;
	wire  [3:0] iev = {bor_ev, nb & (stack_ovf_in | stack_unf_in), any_wake, any_rst};
	// Set beats write-one-to-clear
	wire  [3:0] ist_next = (ist_reg & ~({4{wr_irq}} & wdata_in[3:0])) | iev;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pcf_reg    <= rcr_pkg::PCF_POR_VAL;
			stat_reg   <= rcr_pkg::STAT_POR_VAL;
			sw_brownout_enable_reg <= rcr_pkg::BORCTL_POR_VAL[rcr_pkg::BIT_SW_BROWNOUT_ENABLE];
			ist_reg    <= 4'h0;
			imask_reg  <= 4'h0;
		end else if (clk_en_in) begin
			pcf_reg  <= pcf_next;
			stat_reg <= stat_next;
			ist_reg  <= ist_next;
			if (wr_bctl) begin
				sw_brownout_enable_reg <= wdata_in[rcr_pkg::BIT_SW_BROWNOUT_ENABLE];
			end
			if (wr_irq) begin
				imask_reg <= wdata_in[7:4];
			end
		end
	end

	// ---------------------------------------------
	// Read port
	// ---------------------------------------------
	logic ready_s1_reg;
	logic ready_s2_reg;
	wire [7:0] bctl_rd = {sw_brownout_enable_reg, 6'h00, ready_s2_reg};
	wire [7:0] stat_rd = {3'h0, stat_reg, 3'h0};
	wire [7:0] rd_mux = (addr_in == rcr_pkg::ADDR_BORCTL) ? bctl_rd :
	                    (addr_in == rcr_pkg::ADDR_PCF)    ? pcf_reg :
	                    (addr_in == rcr_pkg::ADDR_STAT)   ? stat_rd :
	                    {imask_reg, ist_reg};

	// ---------------------------------------------
	// Core control outputs
	// ---------------------------------------------
	// vector after next instruction
	wire vec_ev = irq_wk & global_irq_enable_in;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ready_s1_reg           <= 1'b0;
			ready_s2_reg           <= 1'b0;
			rdata_out              <= 8'h00;
			core_reset_out         <= 1'b1;
			pc_load_out            <= 1'b1;
			pc_value_out           <= rcr_pkg::PC_RESET;
			vector_pending_out     <= 1'b0;
			sw_brownout_enable_out <= rcr_pkg::BORCTL_POR_VAL[rcr_pkg::BIT_SW_BROWNOUT_ENABLE];
			irq_out                <= 1'b0;
		end else if (clk_en_in) begin
			ready_s1_reg           <= brownout_ready_in;
			ready_s2_reg           <= ready_s1_reg;
			rdata_out              <= rd_in ? rd_mux : 8'h00;
			core_reset_out         <= any_rst;
			pc_load_out            <= any_rst | any_wake;
			// Wake resumes after the sleep instruction
			pc_value_out           <= any_rst ? rcr_pkg::PC_RESET : pc_in + 16'h0001;
			vector_pending_out     <= vec_ev;
			sw_brownout_enable_out <= sw_brownout_enable_reg;
			irq_out                <= |(ist_next & imask_reg);
		end
	end
endmodule : rcr_reset_cause_recorder

/* verif/rcr_chk.sv */
// Purpose: Port assertions for the reset cause recorder
// Assumes: One clock, clk_en_in high while checked
// Notes:   Pin history keeps wake checks away from pin edges
module rcr_chk (
	input wire logic        ref_clk_in, rstn_in, clk_en_in, wr_in, rd_in, brownout_in,
	input wire logic        instr_reset_in, wdt_expire_in, stack_ovf_in, stack_unf_in,
	input wire logic        irq_wake_in, sleeping_in, global_irq_enable_in,
	input wire logic        stack_reset_enable_in, external_reset_pin_in,
	input wire logic [1:0]  addr_in,
	input wire logic [7:0]  wdata_in, rdata_out,
	input wire logic [15:0] pc_in, pc_value_out,
	input wire logic        core_reset_out, pc_load_out, vector_pending_out, sw_brownout_enable_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pin_hist;
	// Other events would mask a wake or watchdog
	wire calm = &pin_hist && external_reset_pin_in && clk_en_in && !brownout_in
		&& !instr_reset_in && !stack_ovf_in && !stack_unf_in;
	always_ff @(posedge ref_clk_in or negedge rstn_in)
		if (!rstn_in) pin_hist <= 4'h0;
		else pin_hist <= {pin_hist[2:0], external_reset_pin_in};
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	AST_INSTR:
		assert property (instr_reset_in && clk_en_in |=> core_reset_out && pc_value_out == 16'h0000)
		else $error("no reset on instruction");
	AST_BOR:
		assert property (brownout_in && clk_en_in |=> core_reset_out && pc_value_out == 16'h0000)
		else $error("no reset on brown-out");
	AST_STK:
		assert property ((stack_ovf_in || stack_unf_in) && stack_reset_enable_in && clk_en_in
			|=> core_reset_out) else $error("no stack reset");
	AST_WDT:
		assert property (calm && wdt_expire_in && !sleeping_in |=> core_reset_out && pc_load_out)
		else $error("no watchdog reset");
	AST_WAKE:
		assert property (calm && irq_wake_in && sleeping_in |=> pc_load_out && !core_reset_out
			&& pc_value_out == $past(pc_in) + 16'h0001) else $error("bad wake address");
	AST_VEC:
		assert property (calm && irq_wake_in && sleeping_in && global_irq_enable_in
			&& !wdt_expire_in |=> vector_pending_out) else $error("no vector after wake");
	AST_FLG:
		assert property (rd_in && clk_en_in && addr_in == 2'h1 |=> rdata_out[5:4] == 2'b00)
		else $error("flag bits 5:4 set");
	AST_SWEN:
		assert property (wr_in && clk_en_in && addr_in == 2'h0 && wdata_in[7]
			|=> ##1 sw_brownout_enable_out) else $error("enable not written");
endmodule : rcr_chk
bind rcr_reset_cause_recorder rcr_chk u_chk (.*);

/* verif/rcr_core_model.sv */
// Purpose: Behavioural core beside the recorder
// Assumes: One instruction a clock while awake
// Notes:   Sleep request is a one-cycle pulse
module rcr_core_model (
	input  wire logic        clk_in, rstn_in, pc_load_in, vector_in, sleep_in,
	input  wire logic [15:0] pc_value_in,
	output logic [15:0]      pc_out,
	output logic             sleeping_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic vec_reg;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pc_out <= 16'h0000;
			sleeping_out <= 1'b0;
			vec_reg <= 1'b0;
		end else if (pc_load_in) begin
			pc_out <= pc_value_in;
			sleeping_out <= 1'b0;
			vec_reg <= vector_in;
		end else if (vec_reg) begin
			pc_out <= rcr_pkg::PC_VECTOR;
			vec_reg <= 1'b0;
		end else if (sleep_in || sleeping_out) begin
			sleeping_out <= 1'b1;
		end else begin
			pc_out <= pc_out + 16'h0001;
		end
	end
endmodule : rcr_core_model

/* verif/rcr_reset_cause_recorder_tb.sv */
// Purpose: Self-checking bench for the reset cause recorder
// Assumes: 20 MHz clock, power-on through rstn_in
// Notes:   Events are one-cycle pulses from ev
module rcr_reset_cause_recorder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b1, global_irq_enable = 1'b0, sren = 1'b0;
	logic slp = 1'b0, pld, vec, sleeping, irq, crst, swen, rst_q = 1'b0;
	int rst_cnt = 0;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic [5:0] ev = 6'h00;
	logic [15:0] pc, pcv;
	int err_total = 0, checks = 0, cyc = 0;
	always #25 clk = ~clk;
	rcr_reset_cause_recorder i_dut (.ref_clk_in(clk), .rstn_in(rstn), .clk_en_in(1'b1),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .brownout_in(ev[5]),
		.external_reset_pin_in(pin), .instr_reset_in(ev[4]), .wdt_expire_in(ev[3]),
		.stack_ovf_in(ev[2]), .stack_unf_in(ev[1]), .irq_wake_in(ev[0]),
		.global_irq_enable_in(global_irq_enable), .sleeping_in(sleeping), .stack_reset_enable_in(sren),
		.brownout_ready_in(1'b1), .pc_in(pc), .rdata_out(rdata), .core_reset_out(crst),
		.pc_load_out(pld), .pc_value_out(pcv), .vector_pending_out(vec),
		.sw_brownout_enable_out(swen), .irq_out(irq));
	// Count reset pulses, skipping the power-on level
	always @(posedge clk) begin
		rst_q <= rstn;
		if (crst && rst_q)
			rst_cnt++;
	end
	rcr_core_model i_core (.clk_in(clk), .rstn_in(rstn), .pc_load_in(pld), .vector_in(vec),
		.sleep_in(slp), .pc_value_in(pcv), .pc_out(pc), .sleeping_out(sleeping));
	task automatic stop_test;
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d, input logic [5:0] e);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		ev <= e;
		@(posedge clk);
		wr <= 1'b0;
		ev <= 6'h00;
	endtask : wr_reg
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
		repeat (2) @(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd_reg
	task automatic pulse(input int i, input logic nap);
		@(posedge clk);
		slp <= nap;
		@(posedge clk);
		slp <= 1'b0;
		ev <= 6'h01 << i;
		@(posedge clk);
		ev <= 6'h00;
	endtask : pulse
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			stop_test;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd_reg(2'h1, 8'h0C);
		rd_reg(2'h2, 8'h18);
		rd_reg(2'h0, 8'h81);
		wr_reg(2'h0, 8'h00, 6'h00);
		rd_reg(2'h0, 8'h01);
		chk({7'h00, swen}, 8'h00);
		wr_reg(2'h3, 8'hF0, 6'h00);
		wr_reg(2'h1, 8'hFF, 6'h00);
		rd_reg(2'h1, 8'hCF);
		// Same-cycle write and instruction reset
		wr_reg(2'h1, 8'h0F, 6'h10);
		rd_reg(2'h1, 8'h0B);
		chk({7'h00, irq}, 8'h01);
		wr_reg(2'h3, 8'h0F, 6'h00);
		wr_reg(2'h1, 8'h0F, 6'h00);
		chk({7'h00, irq}, 8'h00);
		pin <= 1'b0;
		repeat (6) @(posedge clk);
		pin <= 1'b1;
		rd_reg(2'h1, 8'h07);
		pulse(3, 1'b0);
		rd_reg(2'h2, 8'h08);
		pulse(3, 1'b1);
		rd_reg(2'h2, 8'h00);
		global_irq_enable <= 1'b1;
		pulse(0, 1'b1);
		rd_reg(2'h2, 8'h10);
		wr_reg(2'h1, 8'hCF, 6'h00);
		pulse(5, 1'b0);
		rd_reg(2'h1, 8'h0E);
		rd_reg(2'h2, 8'h18);
		pulse(2, 1'b0);
		rd_reg(2'h1, 8'h8E);
		sren <= 1'b1;
		pulse(1, 1'b0);
		rd_reg(2'h1, 8'hCE);
		chk(8'(rst_cnt), 8'h05);
		stop_test;
	end
endmodule : rcr_reset_cause_recorder_tb
